// [hw/bdm_pkg.sv]
// Purpose: Shared constants and carriers for the banked data memory.
// Assumes: Eight-bit locations, two banks, 256 locations per bank.
// Notes:   Offsets below are location addresses within a bank.
package bdm_pkg;

    // ------------------------------------------------------------
    // Geometry and map
    // ------------------------------------------------------------
    localparam int         DATA_W       = 8;
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_IND0     = 8'h00;
    localparam logic [7:0] OFS_PTR0     = 8'h01;
    localparam logic [7:0] OFS_IND1     = 8'h02;
    localparam logic [7:0] OFS_PTR1     = 8'h03;
    localparam logic [7:0] OFS_BANK     = 8'h04;
    localparam logic [7:0] GP_BASE      = 8'h80;
    localparam logic [7:0] BUF_B_BASE   = 8'hC0;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam int         BANK_BIT     = 0;
    localparam logic       BANK0        = 1'b0;
    localparam logic       BANK1        = 1'b1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Access request from the core datapath.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] bit_mask;
        logic       bit_op;
        logic       bit_val;
    } bdm_req_s;

    // Special-function register port toward the other units.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bdm_sfr_s;

endpackage : bdm_pkg

// [hw/bdm_data_memory.sv]
// Purpose: Banked data memory with two indirect ports and pointers.
// Assumes: Core issues at most one read or write per clock.
// Notes:   Read data is registered, valid the cycle after the request.

module bdm_data_memory #(
    parameter int GP_DEPTH = 128
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Core access request and registered answer.
    input  wire bdm_pkg::bdm_req_s req,
    output logic [7:0]             rdata,
    // Special-function area served by other units.
    output bdm_pkg::bdm_sfr_s      sfr,
    input  wire logic [7:0]        sfr_rdata,
    input  wire logic              sfr_used,
    input  wire logic              sfr_readonly,
    // LED PWM buffer read port for the display engine.
    input  wire logic [6:0]        led_addr,
    output logic [7:0]             led_data,
    // Current bank selection.
    output logic                   bank_sel
);

    // ------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------
    logic [7:0] gp_mem    [GP_DEPTH];
    logic [7:0] led_mem   [GP_DEPTH];
    logic [7:0] ptr0_r;
    logic [7:0] ptr1_r;
    logic       bank_r;
    logic       eff_bank;
    logic [7:0] eff_addr;
    logic       is_ind;
    logic       is_null;
    logic [6:0] idx;
    logic [7:0] cur;
    logic [7:0] wval;
    logic [7:0] rdata_r;

    // ------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------
    // Indirect ports redirect through their pointers; direct access is bank 0.
    always_comb begin
        is_ind   = 1'b0;
        eff_bank = bdm_pkg::BANK0;
        eff_addr = req.addr;
        if (req.addr == bdm_pkg::OFS_IND0) begin
            is_ind   = 1'b1;
            eff_addr = ptr0_r;
            eff_bank = bdm_pkg::BANK0;
        end else if (req.addr == bdm_pkg::OFS_IND1) begin
            is_ind   = 1'b1;
            eff_addr = ptr1_r;
            eff_bank = bank_r;
        end
    end

    // A pointer aimed at an indirect port itself lands on nothing.
    // ports hold nothing
    assign is_null = is_ind && ((eff_addr == bdm_pkg::OFS_IND0) || (eff_addr == bdm_pkg::OFS_IND1));
    assign idx     = eff_addr[6:0];

    // Current contents of the resolved location, for reads and bit ops.
    always_comb begin
        cur = bdm_pkg::ZERO_BYTE;
        if (is_null) begin
            cur = bdm_pkg::ZERO_BYTE;
        end else if (eff_addr[7]) begin
            cur = (eff_bank == bdm_pkg::BANK1) ? led_mem[idx] : gp_mem[idx];
        end else if (eff_bank == bdm_pkg::BANK0) begin
            if (eff_addr == bdm_pkg::OFS_PTR0) begin
                cur = ptr0_r;
            end else if (eff_addr == bdm_pkg::OFS_PTR1) begin
                cur = ptr1_r;
            end else if (eff_addr == bdm_pkg::OFS_BANK) begin
                cur = {7'b0, bank_r};
            end else if (sfr_used) begin
                cur = sfr_rdata;
            end
        end
    end

    // Write value, applying masked bit set or clear onto current contents.
    // bit set clear
    assign wval = req.bit_op ? (req.bit_val ? (cur | req.bit_mask) : (cur & ~req.bit_mask)) : req.wdata;

    // ------------------------------------------------------------
    // Special-function port
    // ------------------------------------------------------------
    // fixed register locations
    always_comb begin
        sfr.addr  = eff_addr[6:0];
        sfr.wdata = wval;
        sfr.rd    = req.rd && !is_null && !eff_addr[7] && (eff_bank == bdm_pkg::BANK0)
                    && (eff_addr > bdm_pkg::OFS_BANK);
        sfr.wr    = req.wr && !is_null && !eff_addr[7] && (eff_bank == bdm_pkg::BANK0) && !sfr_readonly
                    && (eff_addr > bdm_pkg::OFS_BANK);
    end

    // ------------------------------------------------------------
    // Local registers
    // ------------------------------------------------------------
    // Pointers and bank selection live in bank 0 special locations.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ptr0_r <= bdm_pkg::ZERO_BYTE;
            ptr1_r <= bdm_pkg::ZERO_BYTE;
            bank_r <= bdm_pkg::BANK0;
        end else if (req.wr && !is_null && (eff_bank == bdm_pkg::BANK0)) begin
            if (eff_addr == bdm_pkg::OFS_PTR0) begin
                ptr0_r <= wval;
            end
            if (eff_addr == bdm_pkg::OFS_PTR1) begin
                ptr1_r <= wval;
            end
            if (eff_addr == bdm_pkg::OFS_BANK) begin
                bank_r <= wval[bdm_pkg::BANK_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // RAM arrays
    // ------------------------------------------------------------
    // eight-bit banked RAM
    always_ff @(posedge clock) begin
        if (req.wr && !is_null && eff_addr[7]) begin
            if (eff_bank == bdm_pkg::BANK1) begin
                led_mem[idx] <= wval;
            end else begin
                gp_mem[idx] <= wval;
            end
        end
    end

    // Registered read data; LED buffer read for the display engine.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r  <= bdm_pkg::ZERO_BYTE;
            led_data <= bdm_pkg::ZERO_BYTE;
        end else begin
            rdata_r  <= req.rd ? cur : bdm_pkg::ZERO_BYTE;
            led_data <= led_mem[led_addr];
        end
    end

    assign rdata    = rdata_r;
    assign bank_sel = bank_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ind_null_read_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.rd && is_null) |=> (rdata == 8'h00))
        else $error("Indirect port self-read not zero.");

    direct_bank0_a : assert property (@(posedge clock) disable iff (!rst_n)
        (!is_ind) |-> (eff_bank == 1'b0))
        else $error("Direct access left bank 0.");

    port0_bank0_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.addr == 8'h00) |-> (eff_bank == 1'b0 && eff_addr == ptr0_r))
        else $error("First indirect port left bank 0.");

    port1_bank_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.addr == 8'h02) |-> (eff_bank == bank_sel && eff_addr == ptr1_r))
        else $error("Second indirect port address wrong.");

    bank_write_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr == 8'h04) |=> (bank_sel == $past(req.wdata[0])))
        else $error("Bank select did not follow bit 0.");

    unused_zero_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.rd && !req.addr[7] && req.addr > 8'h04 && !sfr_used) |=> (rdata == 8'h00))
        else $error("Unused location read nonzero.");

    protect_write_a : assert property (@(posedge clock) disable iff (!rst_n)
        sfr_readonly |-> !sfr.wr)
        else $error("Write reached a protected register.");

    gp_readback_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr[7]) ##1 (req.rd && req.addr == $past(req.addr))
        |=> (rdata == $past(req.wdata, 2)))
        else $error("General location readback mismatch.");

    direct_gp_write_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr[7]) |=> (gp_mem[$past(req.addr[6:0])] == $past(req.wdata)))
        else $error("Direct write missed bank 0 storage.");

    port0_write_a : assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr == bdm_pkg::OFS_IND0 && ptr0_r[7])
        |=> (gp_mem[$past(ptr0_r[6:0])] == $past(req.wdata)))
        else $error("First indirect port write missed bank 0.");

    sfr_strobe_area_a : assert property (@(posedge clock) disable iff (!rst_n)
        (sfr.rd || sfr.wr) |-> (!eff_addr[7] && eff_addr > bdm_pkg::OFS_BANK && eff_bank == bdm_pkg::BANK0))
        else $error("Special strobe outside its area.");

endmodule : bdm_data_memory

// [sim/bdm_sfr_model.sv]
// Purpose: Special-function unit model facing the data memory.
// Assumes: 05H is read/write, 0AH is protected, all else is unused.
// Notes:   Unused places show a moving pattern so a missing mask shows.
module bdm_sfr_model #(
    parameter logic [7:0] RO_VAL = 8'h5A
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Strobes from the memory and the answers.
    input  wire bdm_pkg::bdm_sfr_s sfr,
    output logic [7:0]             sfr_rdata,
    output logic                   sfr_used,
    output logic                   sfr_readonly
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rw_r;
    logic [7:0] ro_r;
    logic [7:0] pat_r;
    assign sfr_used = (sfr.addr == 7'h05) || (sfr.addr == 7'h0A);
    assign sfr_readonly = (sfr.addr == 7'h0A);
    // Read answer; unused places never show a steady value.
    assign sfr_rdata = (sfr.addr == 7'h05) ? rw_r : ((sfr.addr == 7'h0A) ? ro_r : pat_r);
    // The protected register still latches a stray strobe, so a leak is seen.
    always_ff @(posedge clock) begin
        pat_r <= rst_n ? pat_r + 8'h3B : 8'hC3;
        if (!rst_n) begin
            rw_r <= 8'h00;
            ro_r <= RO_VAL;
        end else if (sfr.wr && sfr.addr == 7'h05) begin
            rw_r <= sfr.wdata;
        end else if (sfr.wr && sfr.addr == 7'h0A) begin
            ro_r <= sfr.wdata;
        end
    end
endmodule : bdm_sfr_model

// [sim/bdm_data_memory_tb.sv]
// Purpose: Self-checking bench for the banked data memory.
// Assumes: One request per cycle, read answer one cycle later.
// Notes:   A reference copy of memory and pointers gives every read and led_data expectation; bank_sel is checked against fixed values.
module bdm_data_memory_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock, rst_n, sfr_used, sfr_readonly, bank_sel, rd_seen, bk_m;
    bdm_pkg::bdm_req_s req;
    bdm_pkg::bdm_sfr_s sfr;
    logic [7:0]        rdata, led_data, sfr_rdata, p0_m, p1_m, acc_m, ro_m, a, mk;
    logic [6:0]        led_addr;
    logic [7:0]        ram_m [512];
    logic [7:0]        exp_q [$];
    int                n_mismatch, check_count, i;
    bdm_data_memory u_bdm_data_memory (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .sfr_used(sfr_used), .sfr_readonly(sfr_readonly), .led_addr(led_addr),
        .led_data(led_data), .bank_sel(bank_sel));
    bdm_sfr_model #(.RO_VAL(8'h5A)) u_bdm_sfr_model (.clock(clock), .rst_n(rst_n), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .sfr_used(sfr_used), .sfr_readonly(sfr_readonly));
    // Clock of 4 ns period.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Effective place of an access as {bank, location}.
    function automatic logic [8:0] eff(input logic [7:0] ad);
        if (ad == 8'h00) return {1'b0, p0_m};
        if (ad == 8'h02) return {bk_m, p1_m};
        return {1'b0, ad};
    endfunction : eff
    // Expected read value of a place.
    function automatic logic [7:0] look(input logic [8:0] e);
        if (e[7]) return ram_m[e];
        if (e[8] || e[7:0] == 8'h00 || e[7:0] == 8'h02) return 8'h00;
        case (e[7:0])
            8'h01: return p0_m;
            8'h03: return p1_m;
            8'h04: return {7'h00, bk_m};
            8'h05: return acc_m;
            8'h0A: return ro_m;
            default: return 8'h00;
        endcase
    endfunction : look
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One request for one cycle; the reference is updated as it is sent.
    task automatic op(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic [7:0] m,
                      input logic bo, input logic bv);
        logic [8:0] e;
        logic [7:0] v;
        e = eff(ad);
        v = bo ? (bv ? (look(e) | m) : (look(e) & ~m)) : d;
        @(posedge clock);
        #1;
        req = '{rd: ~w, wr: w, addr: ad, wdata: d, bit_mask: m, bit_op: bo, bit_val: bv};
        if (!w) exp_q.push_back(look(e));
        else if (e[7]) ram_m[e] = v;
        else if (!e[8] && e[7:0] == 8'h01) p0_m = v;
        else if (!e[8] && e[7:0] == 8'h03) p1_m = v;
        else if (!e[8] && e[7:0] == 8'h04) bk_m = v[0];
        else if (!e[8] && e[7:0] == 8'h05) acc_m = v;
    endtask : op
    task automatic idle;
        @(posedge clock);
        #1;
        req = '0;
    endtask : idle
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Watcher takes the oldest note whenever a read answer stands.
    always @(posedge clock) rd_seen <= req.rd;
    always @(negedge clock) begin
        if (rd_seen === 1'b1) chk(rdata, exp_q.pop_front(), "rdata");
    end
    // Main sequence.
    initial begin
        req = '0;
        led_addr = 7'h00;
        rst_n = 1'b0;
        {p0_m, p1_m, acc_m, bk_m} = '0;
        ro_m = 8'h5A;
        void'($urandom(50));
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        op(0, 8'h01, 0, 0, 0, 0);
        op(0, 8'h03, 0, 0, 0, 0);
        op(0, 8'h04, 0, 0, 0, 0);
        chk({7'h00, bank_sel}, 8'h00, "bank_sel");
        $display("test reset done");
        for (i = 0; i < 12; i++) begin
            a = {1'b1, 7'($urandom)};
            mk = 8'($urandom);
            op(1, a, 8'($urandom), 0, 0, 0);
            op(0, a, 0, 0, 0, 0);
            op(1, a, 0, mk, 1, i[0]);
            op(0, a, 0, 0, 0, 0);
        end
        $display("test general storage done");
        op(1, 8'h05, 8'hA7, 0, 0, 0);
        op(1, 8'h0A, 8'h11, 0, 0, 0);
        op(0, 8'h05, 0, 0, 0, 0);
        op(0, 8'h0A, 0, 0, 0, 0);
        op(0, 8'h0B, 0, 0, 0, 0);
        op(0, 8'h7F, 0, 0, 0, 0);
        $display("test special area done");
        op(1, 8'h01, 8'h90, 0, 0, 0);
        op(1, 8'h04, 8'h01, 0, 0, 0);
        idle();
        chk({7'h00, bank_sel}, 8'h01, "bank_sel");
        op(1, 8'h00, 8'h3C, 0, 0, 0);
        op(0, 8'h90, 0, 0, 0, 0);
        op(1, 8'h03, 8'hC5, 0, 0, 0);
        op(1, 8'h02, 8'h6E, 0, 0, 0);
        op(1, 8'h02, 0, 8'h81, 1, 1);
        op(0, 8'h02, 0, 0, 0, 0);
        op(1, 8'h90, 8'hE1, 0, 0, 0);
        op(0, 8'h00, 0, 0, 0, 0);
        idle();
        led_addr = 7'h45;
        @(posedge clock);
        @(negedge clock);
        chk(led_data, ram_m[{2'b11, led_addr}], "led_data");
        op(1, 8'h03, 8'h10, 0, 0, 0);
        op(0, 8'h02, 0, 0, 0, 0);
        op(1, 8'h01, 8'h02, 0, 0, 0);
        op(1, 8'h00, 8'hFF, 0, 0, 0);
        op(0, 8'h00, 0, 0, 0, 0);
        op(1, 8'h04, 8'h00, 0, 0, 0);
        // A known bank 0 value, so port 1 back on bank 0 is told apart from bank 1.
        op(1, 8'hC5, 8'h5D, 0, 0, 0);
        op(1, 8'h03, 8'hC5, 0, 0, 0);
        op(0, 8'h02, 0, 0, 0, 0);
        op(0, 8'h03, 0, 0, 0, 0);
        idle();
        idle();
        $display("test indirect ports done");
        // Mid-run reset clears pointers, bank select and the accumulator model; RAM keeps its contents.
        op(1, 8'h04, 8'h01, 0, 0, 0);
        idle();
        rst_n = 1'b0;
        {p0_m, p1_m, acc_m, bk_m} = '0;
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        chk({7'h00, bank_sel}, 8'h00, "bank_sel");
        op(0, 8'h01, 0, 0, 0, 0);
        op(0, 8'h90, 0, 0, 0, 0);
        idle();
        idle();
        $display("test mid-run reset done");
        complete_run();
    end
    // Watchdog far beyond the hundred or so cycles of the tests.
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
endmodule : bdm_data_memory_tb
